/* query_pkg.sv */
package query_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_VENDOR     = 8'h01;
  localparam logic [7:0] CMD_MODEL      = 8'h02;
  localparam logic [7:0] CMD_PRODUCT    = 8'h03;
  localparam logic [7:0] CMD_SERIAL     = 8'h04;
  localparam logic [7:0] CMD_CAM_VER    = 8'h05;
  localparam logic [7:0] CMD_CFG_VER    = 8'h06;
  localparam logic [7:0] CMD_MCU_VER    = 8'h40;

  // ----------------------------------------------------------------
  // Frame constants
  // ----------------------------------------------------------------
  localparam logic [7:0] LEN_TEXT       = 8'h10;
  localparam logic [7:0] LEN_VERSION    = 8'h03;
  localparam logic       FLAG_READ      = 1'b1;
  localparam logic       FLAG_REPLY     = 1'b0;
  localparam int         TEXT_BYTES     = 16;
  localparam logic [4:0] HDR_BYTES      = 5'h03;
  localparam logic [4:0] CNT_RESET      = 5'h00;

  // Byte stream element of request and reply frames
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } byte_beat_t;

  // One decoded query
  typedef struct packed {
    logic [7:0] command_identifier;
    logic [7:0] length;
  } query_t;

endpackage

/* request_parser.sv */
`timescale 1ns/100ps
`default_nettype none
module request_parser
  import query_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       rx_valid,
  input  wire byte_beat_t rx_beat,
  output var  logic       query_valid,
  output var  query_t     query,
  input  wire logic       query_ready
);

  // ----------------------------------------------------------------
  // Header capture
  // ----------------------------------------------------------------
  logic [1:0] pos_reg;
  logic [7:0] cmd_reg;
  logic       flag_reg;
  logic       bad_reg;
  logic       pend_reg;
  query_t     query_reg;

  assign query_valid = pend_reg;
  assign query       = query_reg;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pos_reg <= 2'h0;
    end else if (rx_valid) begin
      pos_reg <= rx_beat.last ? 2'h0 : ((pos_reg == 2'h3) ? 2'h3 : pos_reg + 2'h1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cmd_reg  <= 8'h00;
      flag_reg <= 1'b0;
      bad_reg  <= 1'b0;
    end else if (rx_valid) begin
      if (pos_reg == 2'h0) begin
        cmd_reg <= rx_beat.data;
      end
      if (pos_reg == 2'h1) begin
        flag_reg <= rx_beat.data[0];
      end
      // Data bytes on a read request spoil the frame
      bad_reg <= rx_beat.last ? 1'b0 : (pos_reg == 2'h2) | bad_reg;
    end
  end

  // A query waiting on a busy replier is dropped if a new one lands;
  // the host is expected to wait for each reply.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pend_reg  <= 1'b0;
      query_reg <= '0;
    end else if (rx_valid && rx_beat.last && pos_reg == 2'h2 && !bad_reg &&
                 flag_reg == FLAG_READ) begin
      pend_reg  <= 1'b1;
      query_reg <= '{command_identifier: cmd_reg, length: rx_beat.data};
    end else if (query_ready) begin
      pend_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* text_store.sv */
`timescale 1ns/100ps
`default_nettype none
module text_store
  import query_pkg::*;
#(
  parameter int TEXT_LEN = TEXT_BYTES
) (
  input  wire logic [1:0]            sel,
  input  wire logic [3:0]            index,
  input  wire logic [TEXT_LEN*8-1:0] vendor_text,
  input  wire logic [TEXT_LEN*8-1:0] model_text,
  input  wire logic [TEXT_LEN*8-1:0] product_text,
  input  wire logic [TEXT_LEN*8-1:0] serial_text,
  output logic      [7:0]            text_byte
);

  // ----------------------------------------------------------------
  // Byte pick, first character in the top byte
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick(input logic [TEXT_LEN*8-1:0] s,
                                      input logic [3:0] i);
    pick = s[(TEXT_LEN-1-int'(i))*8 +: 8];
  endfunction

  // Strings shorter than 16 carry a zero pad, so the terminator falls out
  always_comb begin
    case (sel)
      2'h0:    text_byte = pick(vendor_text, index);
      2'h1:    text_byte = pick(model_text, index);
      2'h2:    text_byte = pick(product_text, index);
      default: text_byte = pick(serial_text, index);
    endcase
  end

endmodule
`default_nettype wire

/* identity_query_responder.sv */
// Summary of operation
// - Command 0x01 length 16 replies same code with 16 vendor name bytes.
// - Short text ends with a zero byte; full 16-byte text has none.
// - Command 0x02 length 16 replies 16 bytes of model number.
// - Command 0x03 length 16 replies 16 bytes of product ID.
// - Command 0x04 length 16 replies 16 bytes of serial number.
// - Command 0x05 length 3 replies camera version, third byte layout ID.
// - Camera version sends low BCD byte first, high BCD byte second.
// - Command 0x06 length 3 replies config-memory firmware version record.
// - Command 0x40 length 3 replies microcontroller firmware version record.
// - Firmware records send low byte first, high byte second.
// - Requests carry flag 1 and no data; replies carry flag 0.
`timescale 1ns/100ps
`default_nettype none
module identity_query_responder
  import query_pkg::*;
#(
  parameter logic [127:0] VENDOR_TEXT  = 128'h56454E444F52000000000000000000_00,
  parameter logic [127:0] MODEL_TEXT   = 128'h4D4F44454C0000000000000000000000,
  parameter logic [127:0] PRODUCT_TEXT = 128'h30303030303000000000000000000000,
  parameter logic [127:0] SERIAL_TEXT  = 128'h30303030303030300000000000000000,
  parameter logic [15:0]  CAM_VER      = 16'h0100,
  parameter logic [15:0]  CFG_VER      = 16'h0100,
  parameter logic [15:0]  MCU_VER      = 16'h0100,
  parameter logic [7:0]   LAYOUT_ID    = 8'h01
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       rx_valid,
  input  wire byte_beat_t rx_beat,
  output var  logic       tx_valid,
  output var  byte_beat_t tx_beat,
  input  wire logic       tx_ready
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR  = 2'b01,
    ST_DATA = 2'b10
  } state_t;

  state_t     state_reg;
  state_t     state_next;
  logic       query_valid;
  query_t     query;
  logic       query_ready;
  logic [7:0] cmd_reg;
  logic [7:0] len_reg;
  logic [4:0] cnt_reg;
  logic       text_reg;
  logic [1:0] sel_reg;
  logic [7:0] text_byte;
  logic       known;
  logic       is_text;
  logic [7:0] data_byte;
  byte_beat_t beat_next;
  logic       beat_valid_reg;
  byte_beat_t beat_reg;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  request_parser u_parser (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .rx_valid    (rx_valid),
    .rx_beat     (rx_beat),
    .query_valid (query_valid),
    .query       (query),
    .query_ready (query_ready)
  );

  text_store #(
    .TEXT_LEN (TEXT_BYTES)
  ) u_text (
    .sel          (sel_reg),
    .index        (cnt_reg[3:0]),
    .vendor_text  (VENDOR_TEXT),
    .model_text   (MODEL_TEXT),
    .product_text (PRODUCT_TEXT),
    .serial_text  (SERIAL_TEXT),
    .text_byte    (text_byte)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Only the exact code and length pair is answered; anything else is
  // swallowed silently, as an unknown query has no defined reply.
  always_comb begin
    known   = 1'b0;
    is_text = 1'b0;
    case (query.command_identifier)
      CMD_VENDOR, CMD_MODEL, CMD_PRODUCT, CMD_SERIAL: begin
        known   = (query.length == LEN_TEXT);
        is_text = 1'b1;
      end
      CMD_CAM_VER, CMD_CFG_VER, CMD_MCU_VER: begin
        known = (query.length == LEN_VERSION);
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  assign query_ready = (state_reg == ST_IDLE);

  // ----------------------------------------------------------------
  // Version record bytes
  // ----------------------------------------------------------------
  function automatic logic [7:0] ver_byte(input logic [15:0] v,
                                          input logic [4:0] i,
                                          input logic [7:0] lid);
    case (i)
      5'h00:   ver_byte = v[7:0];
      5'h01:   ver_byte = v[15:8];
      default: ver_byte = lid;
    endcase
  endfunction

  always_comb begin
    case (cmd_reg)
      CMD_CAM_VER: data_byte = ver_byte(CAM_VER, cnt_reg, LAYOUT_ID);
      CMD_CFG_VER: data_byte = ver_byte(CFG_VER, cnt_reg, LAYOUT_ID);
      CMD_MCU_VER: data_byte = ver_byte(MCU_VER, cnt_reg, LAYOUT_ID);
      default:     data_byte = text_byte;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // One output register stage: a byte is loaded only when the slot is
  // empty or drains this cycle, so back-pressure stalls the counter.
  logic slot_free;
  assign slot_free = !beat_valid_reg || tx_ready;

  always_comb begin
    state_next = state_reg;
    beat_next  = '{data: 8'h00, last: 1'b0};
    case (state_reg)
      ST_IDLE: begin
        if (query_valid && known) begin
          state_next = ST_HDR;
        end
      end
      ST_HDR: begin
        case (cnt_reg)
          5'h00:   beat_next.data = cmd_reg;
          5'h01:   beat_next.data = {7'h00, FLAG_REPLY};
          default: beat_next.data = len_reg;
        endcase
        if (slot_free && cnt_reg == HDR_BYTES - 5'h01) begin
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        beat_next.data = data_byte;
        beat_next.last = (cnt_reg == len_reg[4:0] - 5'h01);
        if (slot_free && beat_next.last) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cmd_reg  <= 8'h00;
      len_reg  <= 8'h00;
      text_reg <= 1'b0;
      sel_reg  <= 2'h0;
    end else if (state_reg == ST_IDLE && query_valid && known) begin
      cmd_reg  <= query.command_identifier;
      len_reg  <= query.length;
      text_reg <= is_text;
      sel_reg  <= query.command_identifier[1:0] - 2'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cnt_reg <= CNT_RESET;
    end else if (state_reg == ST_IDLE) begin
      cnt_reg <= CNT_RESET;
    end else if (slot_free) begin
      cnt_reg <= (state_next != state_reg) ? CNT_RESET : cnt_reg + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      beat_valid_reg <= 1'b0;
      beat_reg       <= '0;
    end else if (slot_free) begin
      beat_valid_reg <= (state_reg != ST_IDLE);
      beat_reg       <= beat_next;
    end
  end

  assign tx_valid = beat_valid_reg;
  assign tx_beat  = beat_reg;

endmodule
`default_nettype wire

/* query_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module query_asserts
  import query_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       rx_valid,
  input wire byte_beat_t rx_beat,
  input wire logic       tx_valid,
  input wire byte_beat_t tx_beat,
  input wire logic       tx_ready
);
  // ------------------------------------------------------------
  // Frame position trackers
  // ------------------------------------------------------------
  logic [4:0] idx_reg;
  logic [7:0] hcode_reg;
  logic [1:0] rcnt_reg;
  logic [7:0] rb0_reg;
  logic       rflag_reg;
  wire logic  take = tx_valid && tx_ready;
  wire logic  is_text = rb0_reg >= CMD_VENDOR && rb0_reg <= CMD_SERIAL;
  wire logic  is_ver = rb0_reg == CMD_CAM_VER || rb0_reg == CMD_CFG_VER || rb0_reg == CMD_MCU_VER;
  wire logic  h_text = hcode_reg <= CMD_SERIAL;
  always_ff @(posedge clk_sys) begin
    if (!nrst) idx_reg <= 5'h00;
    else if (take) idx_reg <= tx_beat.last ? 5'h00 : idx_reg + 5'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (take && idx_reg == 5'h00) hcode_reg <= tx_beat.data;
  end
  // Saturating count, so over-long frames never look legal
  always_ff @(posedge clk_sys) begin
    if (!nrst) rcnt_reg <= 2'h0;
    else if (rx_valid)
      rcnt_reg <= rx_beat.last ? 2'h0 : (rcnt_reg == 2'h3 ? 2'h3 : rcnt_reg + 2'h1);
  end
  always_ff @(posedge clk_sys) begin
    if (rx_valid && rcnt_reg == 2'h0) rb0_reg <= rx_beat.data;
    if (rx_valid && rcnt_reg == 2'h1) rflag_reg <= rx_beat.data[0];
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence good_req_s;
    rx_valid && rx_beat.last && rcnt_reg == 2'h2 && rflag_reg &&
      ((is_text && rx_beat.data == LEN_TEXT) || (is_ver && rx_beat.data == LEN_VERSION));
  endsequence
  sequence idle_s;
    !tx_valid && idx_reg == 5'h00;
  endsequence
  sequence flag_pos_s;
    tx_valid && idx_reg == 5'h01;
  endsequence
  // Length byte, accept, load: the first reply byte is seen three edges on
  reply_start_a: assert property (good_req_s ##0 idle_s |-> ##3 (tx_valid && tx_beat.data == $past(rb0_reg, 3))) else $error("reply did not start with the code");
  flag_clear_a: assert property (flag_pos_s |-> tx_beat.data == 8'h00) else $error("reply flag byte not zero");
  length_field_a: assert property (tx_valid && idx_reg == 5'h02 |-> tx_beat.data == (h_text ? LEN_TEXT : LEN_VERSION)) else $error("reply length wrong");
  last_place_a: assert property (tx_valid && idx_reg >= 5'h03 |-> tx_beat.last == (idx_reg == (h_text ? 5'h12 : 5'h05))) else $error("last marker misplaced");
  head_nolast_a: assert property (tx_valid && idx_reg < 5'h03 |-> !tx_beat.last) else $error("last marker in header");
  beat_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_beat)) else $error("reply byte dropped while stalled");
  next_byte_a: assert property (take && !tx_beat.last |=> tx_valid) else $error("reply gap inside frame");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=> !tx_valid && tx_beat == '0) else $error("output active in reset");
endmodule
bind identity_query_responder query_asserts chk (.clk_sys(clk_sys), .nrst(nrst),
  .rx_valid(rx_valid), .rx_beat(rx_beat), .tx_valid(tx_valid), .tx_beat(tx_beat),
  .tx_ready(tx_ready));
`default_nettype wire

/* query_host.sv */
`timescale 1ns/100ps
`default_nettype none
module query_host
  import query_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       slow,
  input  wire logic       clr,
  input  wire logic       tx_valid,
  input  wire byte_beat_t tx_beat,
  output var  logic       tx_ready
);
  byte_beat_t got [0:31];
  int         n;
  initial tx_ready = 1'b1;
  // Slow sink stalls every other cycle to exercise holding
  always @(negedge clk_sys) tx_ready <= slow ? ~tx_ready : 1'b1;
  always @(posedge clk_sys) begin
    if (clr) n <= 0;
    else if (tx_valid && tx_ready && n < 32) begin
      got[n] <= tx_beat;
      n <= n + 1;
    end
  end
endmodule
`default_nettype wire

/* test_identity_query_responder.sv */
`timescale 1ns/100ps
`default_nettype none
module test_identity_query_responder
  import query_pkg::*;
;
  localparam logic [127:0] V_T = 128'h54455354000000000000000000000000;
  localparam logic [127:0] M_T = 128'h4142434445464748494A4B4C4D4E4F50;
  localparam logic [127:0] P_T = 128'h50310000000000000000000000000000;
  localparam logic [127:0] S_T = 128'h53390000000000000000000000000000;
  localparam logic [15:0]  CV  = 16'h1234;
  localparam logic [15:0]  FV  = 16'h0567;
  localparam logic [15:0]  UV  = 16'h2890;
  localparam logic [7:0]   LID = 8'h5A;
  logic       clk_sys, nrst, rx_valid, tx_valid, tx_ready, slow, clr;
  byte_beat_t rx_beat, tx_beat;
  int         errors, checks_done;
  identity_query_responder #(.VENDOR_TEXT(V_T), .MODEL_TEXT(M_T), .PRODUCT_TEXT(P_T),
    .SERIAL_TEXT(S_T), .CAM_VER(CV), .CFG_VER(FV), .MCU_VER(UV), .LAYOUT_ID(LID)) DUT (
    .clk_sys(clk_sys), .nrst(nrst), .rx_valid(rx_valid), .rx_beat(rx_beat),
    .tx_valid(tx_valid), .tx_beat(tx_beat), .tx_ready(tx_ready));
  query_host host (.clk_sys(clk_sys), .slow(slow), .clr(clr), .tx_valid(tx_valid),
    .tx_beat(tx_beat), .tx_ready(tx_ready));
  always #25 clk_sys = ~clk_sys;
  task automatic close_out;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request frames are three bytes, no data, one byte per cycle
  task automatic query(input logic [7:0] c, f, l, input logic [127:0] body, input int nb);
    logic [7:0] hdr [3];
    int         i;
    hdr = '{c, f, l};
    @(negedge clk_sys) clr = 1'b1;
    @(negedge clk_sys) clr = 1'b0;
    for (i = 0; i < 3; i++) begin
      rx_valid = 1'b1;
      rx_beat = '{data: hdr[i], last: i == 2};
      @(negedge clk_sys);
    end
    rx_valid = 1'b0;
    for (i = 0; i < 200 && host.n < nb + 3; i++) @(negedge clk_sys);
    if (nb > 0 && i == 200) begin
      errors++;
      close_out();
    end
    repeat (4) @(negedge clk_sys);
    check(9'(host.n), nb == 0 ? 9'h000 : 9'(nb + 3));
    for (i = 0; i < nb + 3 && nb > 0; i++)
      check(host.got[i], i == 0 ? {c, 1'b0} : i == 1 ? 9'h000 : i == 2 ? {l, 1'b0} :
        {body[127 - 8 * (i - 3) -: 8], i == nb + 2});
  endtask
  task automatic t_text;
    query(CMD_VENDOR, 8'h01, LEN_TEXT, V_T, 16);
    query(CMD_MODEL, 8'h01, LEN_TEXT, M_T, 16);
    query(CMD_PRODUCT, 8'h01, LEN_TEXT, P_T, 16);
    query(CMD_SERIAL, 8'h01, LEN_TEXT, S_T, 16);
    $display("t_text done");
  endtask
  task automatic t_version;
    slow = 1'b1;
    query(CMD_CAM_VER, 8'h01, LEN_VERSION, {CV[7:0], CV[15:8], LID, 104'h0}, 3);
    query(CMD_CFG_VER, 8'h01, LEN_VERSION, {FV[7:0], FV[15:8], LID, 104'h0}, 3);
    query(CMD_MCU_VER, 8'h01, LEN_VERSION, {UV[7:0], UV[15:8], LID, 104'h0}, 3);
    slow = 1'b0;
    $display("t_version done");
  endtask
  // Malformed queries get no answer at all
  task automatic t_refuse;
    query(CMD_VENDOR, 8'h00, LEN_TEXT, '0, 0);
    query(CMD_CAM_VER, 8'h01, LEN_TEXT, '0, 0);
    query(8'h41, 8'h01, LEN_VERSION, '0, 0);
    query(CMD_SERIAL, 8'h01, LEN_VERSION, '0, 0);
    $display("t_refuse done");
  endtask
  task automatic t_reset;
    fork
      query(CMD_MODEL, 8'h01, LEN_TEXT, M_T, 0);
      begin
        // Reset lands after the last request byte is taken but before the query is accepted
        repeat (5) @(negedge clk_sys);
        nrst = 1'b0;
        repeat (2) @(negedge clk_sys);
        check({tx_valid, 8'h00}, 9'h000);
        nrst = 1'b1;
      end
    join
    query(CMD_VENDOR, 8'h01, LEN_TEXT, V_T, 16);
    $display("t_reset done");
  endtask
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    rx_valid = 1'b0;
    rx_beat = '0;
    slow = 1'b0;
    clr = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys) nrst = 1'b1;
    t_text();
    t_version();
    t_refuse();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
